// >>> logic/sts1sb_pkg.sv
// Shared constants and carrier types for the STS-1 slip buffer block.
// Assumes a single reference clock that samples both line clocks.
package sts1sb_pkg;

	// Clock rates: reference clock and nominal STS-1 line clock
	localparam int REF_CLK_KHZ  = 200000;
	localparam int LINE_CLK_KHZ = 51840;
	// Reference cycles per line clock period, rounded down
	localparam int REF_PER_LINE = REF_CLK_KHZ / LINE_CLK_KHZ;

	// Frame geometry in bytes
	localparam logic [3:0] FRM_ROWS    = 4'h9;
	localparam logic [6:0] FRM_COLS    = 7'h5A;
	localparam logic [6:0] TOH_COLS    = 7'h03;
	localparam logic [3:0] PTR_ROW     = 4'h3;
	localparam logic [6:0] COL_H1      = 7'h00;
	localparam logic [6:0] COL_H2      = 7'h01;
	localparam logic [6:0] COL_H3      = 7'h02;
	localparam logic [6:0] COL_STUFF   = 7'h03;

	// Pointer word layout
	localparam logic [3:0] NDF_NORMAL  = 4'h6;
	localparam logic [1:0] SS_BITS     = 2'h0;
	localparam logic [9:0] PTR_MAX     = 10'h30F;
	localparam logic [9:0] PTR_RESET   = 10'h000;
	localparam logic [9:0] PTR_I_MASK  = 10'h2AA;
	localparam logic [9:0] PTR_D_MASK  = 10'h155;
	localparam logic [7:0] FILL_BYTE   = 8'h00;

	// Slip buffer size and fill thresholds
	localparam int         BUF_AW      = 4;
	localparam logic [4:0] FILL_LOW    = 5'h04;
	localparam logic [4:0] FILL_HIGH   = 5'h0C;
	localparam logic [4:0] FILL_FULL   = 5'h10;

	// Positions of the sampled pins inside the synchroniser
	localparam int PIN_WCLK = 0;
	localparam int PIN_WSPE = 1;
	localparam int PIN_WDAT = 2;
	localparam int PIN_RCLK = 10;
	localparam int PIN_W    = 11;

	typedef enum logic [1:0] {
		ADJ_NONE,
		ADJ_INC,
		ADJ_DEC
	} sts1sb_adj_e;

	typedef struct packed {
		logic       valid;
		logic       frame;
		logic       stuff;
		logic [7:0] data;
	} sts1sb_tx_s;

endpackage

// >>> logic/sts1sb_pin_sync.sv
// Two-stage synchroniser with edge detection for a group of pins.
// Assumes pins are asynchronous to i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
module sts1sb_pin_sync
#(
	parameter int W = 1
)
(
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_lvl,
	output logic      [W-1:0] o_rise,
	output logic      [W-1:0] o_fall
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] last;
	} sts1sb_sync_s;

	sts1sb_sync_s st_q;
	sts1sb_sync_s st_d;

	always_comb
	begin
		st_d      = st_q;
		st_d.meta = i_pin;
		st_d.sync = st_q.meta;
		st_d.last = st_q.sync;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign o_lvl  = st_q.sync;
	assign o_rise = st_q.sync & ~st_q.last;
	assign o_fall = ~st_q.sync & st_q.last;
endmodule // sts1sb_pin_sync
`default_nettype wire

// >>> logic/sts1sb_slip_fifo.sv
// Byte slip buffer with fill count, single reference clock.
// Assumes write and read requests are one-cycle strobes.
`timescale 1ns/100ps
`default_nettype none
module sts1sb_slip_fifo
	import sts1sb_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_wr_data,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rd_data,
	output logic      [4:0]  o_fill
);
	localparam int DEPTH = 1 << BUF_AW;

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [BUF_AW:0]       wp;
		logic [BUF_AW:0]       rp;
	} sts1sb_fifo_s;

	sts1sb_fifo_s st_q;
	sts1sb_fifo_s st_d;
	logic         full;
	logic         empty;

	assign o_fill = st_q.wp - st_q.rp;
	assign full   = (o_fill == FILL_FULL);
	assign empty  = (o_fill == 5'h00);
	// An empty buffer answers with fill bytes
	assign o_rd_data = empty ? FILL_BYTE : st_q.mem[st_q.rp[BUF_AW-1:0]];

	always_comb
	begin
		st_d = st_q;
		if (i_wr && !full)
		begin
			st_d.mem[st_q.wp[BUF_AW-1:0]] = i_wr_data;
			st_d.wp = st_q.wp + 1'b1;
		end
		if (i_rd && !empty)
			st_d.rp = st_q.rp + 1'b1;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule // sts1sb_slip_fifo
`default_nettype wire

// >>> logic/sts1sb_pointer_adjust.sv
// STS-1 slip buffer with pointer adjustment on the outgoing frame.
// Assumes upstream launches data on the rising edge of its write clock;
// payload bytes are captured on the falling edge. Both line clocks are
// pins sampled by i_ref_clk, which must run well above the line rate.
`timescale 1ns/100ps
`default_nettype none
module sts1sb_pointer_adjust
	import sts1sb_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_upstream_write_clock,
	input  wire logic       i_wr_spe,
	input  wire logic [7:0] i_wr_byte,
	input  wire logic       i_local_read_clock,
	output sts1sb_tx_s      o_tx,
	output logic      [9:0] o_ptr_value,
	output logic      [1:0] o_adj,
	output logic      [4:0] o_fill
);
	////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [3:0]  row;
		logic [6:0]  col;
		logic [9:0]  ptr;
		sts1sb_adj_e adj;
		logic        prev_adj;
		sts1sb_tx_s  tx;
		logic [4:0]  fill;
	} sts1sb_state_s;

	sts1sb_state_s st_q;
	sts1sb_state_s st_d;

	logic [PIN_W-1:0] pin_lvl;
	logic [PIN_W-1:0] pin_rise;
	logic [PIN_W-1:0] pin_fall;
	logic             wr_stb;
	logic             rd_edge;
	logic             rd_stb;
	logic [7:0]       buf_data;
	logic [4:0]       buf_fill;

	////////////////////////////////////////////////////////////////////
	// Helpers

	// Pointer word as sent, with the flag bits of an adjustment inverted
	function automatic logic [15:0] ptr_word(input logic [9:0] p, input sts1sb_adj_e a);
		logic [9:0] v;
		v = p;
		if (a == ADJ_INC)
			v = p ^ PTR_I_MASK;
		else if (a == ADJ_DEC)
			v = p ^ PTR_D_MASK;
		ptr_word = {NDF_NORMAL, SS_BITS, v};
	endfunction

	function automatic logic [9:0] ptr_next(input logic [9:0] p, input sts1sb_adj_e a);
		ptr_next = p;
		if (a == ADJ_INC)
			ptr_next = (p >= PTR_MAX) ? 10'h000 : p + 10'h001;
		else if (a == ADJ_DEC)
			ptr_next = (p == 10'h000 || p > PTR_MAX) ? PTR_MAX : p - 10'h001;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Pin sampling and slip buffer

	sts1sb_pin_sync #(
		.W (PIN_W)
	) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_pin     ({i_local_read_clock, i_wr_byte, i_wr_spe, i_upstream_write_clock}),
		.o_lvl     (pin_lvl),
		.o_rise    (pin_rise),
		.o_fall    (pin_fall)
	);

	// Capture on the falling edge, mid-way through the upstream byte
	assign wr_stb  = pin_fall[PIN_WCLK] & pin_lvl[PIN_WSPE];
	assign rd_edge = pin_rise[PIN_RCLK];

	sts1sb_slip_fifo u_fifo (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_wr      (wr_stb),
		.i_wr_data (pin_lvl[PIN_WDAT +: 8]),
		.i_rd      (rd_stb),
		.o_rd_data (buf_data),
		.o_fill    (buf_fill)
	);

	////////////////////////////////////////////////////////////////////
	// Outgoing frame

	logic in_toh;
	logic at_ptr_row;
	logic is_stuff;
	logic h3_payload;
	logic frame_end;

	assign in_toh     = (st_q.col < TOH_COLS);
	assign at_ptr_row = (st_q.row == PTR_ROW);
	assign is_stuff   = at_ptr_row && st_q.col == COL_STUFF && st_q.adj == ADJ_INC;
	assign h3_payload = at_ptr_row && st_q.col == COL_H3 && st_q.adj == ADJ_DEC;
	assign frame_end  = (st_q.row == FRM_ROWS - 4'h1) && (st_q.col == FRM_COLS - 7'h01);

	// A stuff byte reads nothing; H3 reads during a negative stuff
	assign rd_stb = rd_edge && ((!in_toh && !is_stuff) || h3_payload);

	always_comb
	begin
		logic [15:0] pw;
		logic        adj_now;
		pw      = ptr_word(st_q.ptr, st_q.adj);
		adj_now = 1'b0;
		st_d          = st_q;
		st_d.fill     = buf_fill;
		st_d.tx.valid = 1'b0;
		if (rd_edge)
		begin
			st_d.tx.valid = 1'b1;
			st_d.tx.frame = (st_q.row == 4'h0) && (st_q.col == 7'h00);
			st_d.tx.stuff = is_stuff;
			if (in_toh)
			begin
				st_d.tx.data = FILL_BYTE;
				if (at_ptr_row && st_q.col == COL_H1)
					st_d.tx.data = pw[15:8];
				else if (at_ptr_row && st_q.col == COL_H2)
					st_d.tx.data = pw[7:0];
				else if (h3_payload)
					st_d.tx.data = buf_data;
			end
			else if (is_stuff)
				st_d.tx.data = FILL_BYTE;
			else
				st_d.tx.data = buf_data;
			// Byte position advance
			if (st_q.col == FRM_COLS - 7'h01)
			begin
				st_d.col = 7'h00;
				st_d.row = frame_end ? 4'h0 : st_q.row + 4'h1;
			end
			else
				st_d.col = st_q.col + 7'h01;
			// Frame boundary: apply the pending adjustment, pick the next
			if (frame_end)
			begin
				st_d.ptr = ptr_next(st_q.ptr, st_q.adj);
				adj_now  = (st_q.adj != ADJ_NONE);
				st_d.prev_adj = adj_now;
				if (adj_now)
					st_d.adj = ADJ_NONE;
				else if (buf_fill < FILL_LOW)
					st_d.adj = ADJ_INC;
				else if (buf_fill > FILL_HIGH)
					st_d.adj = ADJ_DEC;
				else
					st_d.adj = ADJ_NONE;
			end
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			st_q          <= '0;
			st_q.ptr      <= PTR_RESET;
			st_q.adj      <= ADJ_NONE;
			st_q.tx.data  <= FILL_BYTE;
		end
		else
			st_q <= st_d;
	end

	assign o_tx        = st_q.tx;
	assign o_ptr_value = st_q.ptr;
	assign o_adj       = st_q.adj;
	assign o_fill      = st_q.fill;
endmodule // sts1sb_pointer_adjust
`default_nettype wire

// >>> sim/sts1sb_pa_checker.sv
// Assertions on the ports of the pointer adjuster.
// Assumes binding into sts1sb_pointer_adjust; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module sts1sb_pa_checker
	import sts1sb_pkg::*;
(
	input wire logic       i_ref_clk,
	input wire logic       i_rst,
	input wire logic       i_upstream_write_clock,
	input wire logic       i_wr_spe,
	input wire logic [7:0] i_wr_byte,
	input wire logic       i_local_read_clock,
	input wire sts1sb_tx_s o_tx,
	input wire logic [9:0] o_ptr_value,
	input wire logic [1:0] o_adj,
	input wire logic [4:0] o_fill
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	property p_valid_pulse;
		o_tx.valid |=> !o_tx.valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("long valid");
	property p_read_edge;
		$rose(i_local_read_clock) |-> ##[2:6] o_tx.valid;
	endproperty
	a_read_edge: assert property (p_read_edge) else $error("no byte out");
	property p_ptr_range;
		o_ptr_value <= PTR_MAX;
	endproperty
	a_ptr_range: assert property (p_ptr_range) else $error("bad pointer");
	property p_no_b2b;
		$changed(o_adj) && $past(o_adj) != ADJ_NONE |-> o_adj == ADJ_NONE;
	endproperty
	a_no_b2b: assert property (p_no_b2b) else $error("back to back");
	property p_inc_next;
		$past(o_adj) == ADJ_INC && o_adj != ADJ_INC |-> o_ptr_value ==
			(($past(o_ptr_value) == PTR_MAX) ? 10'h000 : $past(o_ptr_value) + 10'h001);
	endproperty
	a_inc_next: assert property (p_inc_next) else $error("no increment");
	property p_dec_next;
		$past(o_adj) == ADJ_DEC && o_adj != ADJ_DEC |-> o_ptr_value ==
			(($past(o_ptr_value) == 10'h000) ? PTR_MAX : $past(o_ptr_value) - 10'h001);
	endproperty
	a_dec_next: assert property (p_dec_next) else $error("no decrement");
	property p_ptr_hold;
		$changed(o_ptr_value) |-> $past(o_adj) != ADJ_NONE && o_adj == ADJ_NONE;
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
	property p_stuff;
		o_tx.valid && o_tx.stuff |-> o_adj == ADJ_INC && o_tx.data == FILL_BYTE;
	endproperty
	a_stuff: assert property (p_stuff) else $error("stray stuff");
	property p_inc_cause;
		$changed(o_adj) && o_adj == ADJ_INC |-> $past(o_fill) <= FILL_LOW;
	endproperty
	a_inc_cause: assert property (p_inc_cause) else $error("inc not low");
	property p_dec_cause;
		$changed(o_adj) && o_adj == ADJ_DEC |-> $past(o_fill) >= FILL_HIGH;
	endproperty
	a_dec_cause: assert property (p_dec_cause) else $error("dec not high");
endmodule // sts1sb_pa_checker
bind sts1sb_pointer_adjust sts1sb_pa_checker u_sts1sb_pa_checker (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_upstream_write_clock(i_upstream_write_clock),
	.i_wr_spe(i_wr_spe), .i_wr_byte(i_wr_byte), .i_local_read_clock(i_local_read_clock),
	.o_tx(o_tx), .o_ptr_value(o_ptr_value), .o_adj(o_adj), .o_fill(o_fill));
`default_nettype wire

// >>> sim/sts1sb_upstream_model.sv
// Upstream terminal: free-running write clock and payload bytes.
// Assumes the bench sets the half period and offers the next byte.
`timescale 1ns/100ps
`default_nettype none
module sts1sb_upstream_model
(
	input  wire logic [7:0] i_half_ns,
	input  wire logic [7:0] i_next,
	output logic            o_clk,
	output logic            o_spe,
	output logic [7:0]      o_byte
);
	initial
	begin
		o_clk = 1'b0;
		o_spe = 1'b1;
		o_byte = 8'h00;
		#1;
		forever
			#(i_half_ns) o_clk = ~o_clk;
	end
	// Launch on the rise so the byte is steady at the fall
	always @(posedge o_clk)
		o_byte <= i_next;
endmodule // sts1sb_upstream_model
`default_nettype wire

// >>> sim/tb_top.sv
// Bench for the pointer adjuster: slow then fast upstream.
// Assumes the upstream model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import sts1sb_pkg::*;
;
	logic        ref_clk = 1'b0, rst = 1'b1, rd_clk = 1'b0, wr_clk, wr_spe, post;
	logic [7:0]  wr_byte, half_ns, h1;
	logic [31:0] seed = 32'h73BD;
	logic [15:0] word, norm;
	logic [9:0]  ptr, ptr_exp;
	logic [1:0]  adj;
	logic [4:0]  fill;
	sts1sb_tx_s  tx;
	sts1sb_adj_e q[$], cur, kind, pend;
	int          n_fail, check_count, n_adj, idx;
	always #2.5 ref_clk = ~ref_clk;
	always #32 rd_clk = ~rd_clk;
	sts1sb_upstream_model u_sts1sb_upstream_model (.i_half_ns(half_ns), .i_next(seed[7:0]),
		.o_clk(wr_clk), .o_spe(wr_spe), .o_byte(wr_byte));
	sts1sb_pointer_adjust u_sts1sb_pointer_adjust (.i_ref_clk(ref_clk), .i_rst(rst),
		.i_upstream_write_clock(wr_clk), .i_wr_spe(wr_spe), .i_wr_byte(wr_byte),
		.i_local_read_clock(rd_clk), .o_tx(tx), .o_ptr_value(ptr), .o_adj(adj), .o_fill(fill));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] s;
		s = v ^ (v << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	always @(posedge ref_clk)
		seed <= xs(seed);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks=%0d failures=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_adj(input int n);
		int k;
		for (k = 0; k < 50000 && !(n_adj >= n && post); k++)
			@(posedge ref_clk);
		if (k == 50000)
		begin
			n_fail++;
			$display("ERROR t=%0t adj=%h want=%h", $time, n_adj, n);
			results();
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Monitor: rebuild the pointer word per frame and match notes
	always @(posedge ref_clk)
	begin
		if (!rst && tx.valid === 1'b1)
		begin
			idx = tx.frame ? 0 : idx + 1;
			if (idx == 270)
				h1 = tx.data;
			if (idx == 271)
			begin
				word = {h1, tx.data};
				kind = ADJ_NONE;
				if (pend == ADJ_INC)
					ptr_exp = (ptr_exp == PTR_MAX) ? 10'h000 : ptr_exp + 10'h001;
				if (pend == ADJ_DEC)
					ptr_exp = (ptr_exp == 10'h000) ? PTR_MAX : ptr_exp - 10'h001;
				norm = {NDF_NORMAL, SS_BITS, ptr_exp};
				if (pend == ADJ_NONE && word === (norm ^ {6'h00, PTR_I_MASK}))
					kind = ADJ_INC;
				if (pend == ADJ_NONE && word === (norm ^ {6'h00, PTR_D_MASK}))
					kind = ADJ_DEC;
				if (kind == ADJ_NONE)
					chk(word, norm);
				else
				begin
					if (q.size() > 0)
						cur = q.pop_front();
					chk(16'(kind), 16'(cur));
				end
				chk(16'(adj), 16'(kind));
				chk(16'(ptr), 16'(ptr_exp));
				n_adj += int'(kind != ADJ_NONE);
				post = (pend != ADJ_NONE);
				pend = kind;
			end
			if (idx == 273)
				chk(16'(tx.stuff), 16'(kind == ADJ_INC));
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		n_fail = 0;
		check_count = 0;
		n_adj = 0;
		idx = 1000;
		post = 1'b0;
		pend = ADJ_NONE;
		cur = ADJ_NONE;
		kind = ADJ_NONE;
		ptr_exp = PTR_RESET;
		half_ns = 8'h24;
		q.push_back(ADJ_INC);
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		wait_adj(2);
		half_ns <= 8'h1F;
		q.push_back(ADJ_DEC);
		wait_adj(4);
		chk(16'(q.size()), 16'h0000);
		results();
	end
endmodule // tb_top
`default_nettype wire
